// ===== core/ppa_pkg.sv
// Constants, register indices and carrier types for the port pad
// configuration and analog port data block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.

package ppa_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DW = 8;
    localparam int WB_AW = 16;
    localparam int WB_DW = 32;
    localparam int WB_SW = 4;
    localparam int IDX_W = 14;
    localparam int ADR_IDX_LSB = 2;
    localparam int ADR_IDX_MSB = 15;
    localparam int SEL_LANE0 = 0;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_PH_DIR = 14'h0262;
    localparam logic [IDX_W-1:0] IDX_PH_DRIVE = 14'h0263;
    localparam logic [IDX_W-1:0] IDX_PH_PULL_EN = 14'h0264;
    localparam logic [IDX_W-1:0] IDX_PH_PULL_POL = 14'h0265;
    localparam logic [IDX_W-1:0] IDX_PH_OPEN_DRAIN = 14'h0266;
    localparam logic [IDX_W-1:0] IDX_RSVD_A = 14'h0267;
    localparam logic [IDX_W-1:0] IDX_RSVD_B = 14'h0268;
    localparam logic [IDX_W-1:0] IDX_RSVD_C = 14'h0269;
    localparam logic [IDX_W-1:0] IDX_AD_DATA = 14'h0271;
    localparam logic [IDX_W-1:0] IDX_RSVD_AD = 14'h0272;
    localparam logic [IDX_W-1:0] IDX_AD_DIR = 14'h0273;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DW-1:0] RST_ZERO = 8'h00;
    localparam logic [DW-1:0] RST_PULL_EN = 8'hFF;
    localparam logic [DW-1:0] RSVD_READ = 8'h00;
    localparam logic [WB_DW-DW-1:0] UPPER_ZERO = 24'h000000;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_AW-1:0] adr;
        logic [WB_SW-1:0] sel;
        logic [WB_DW-1:0] dat;
    } ppa_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [WB_DW-1:0] dat;
    } ppa_wb_rsp_t;

    typedef struct packed {
        logic [DW-1:0] dout;
        logic [DW-1:0] oe;
        logic [DW-1:0] reduced;
        logic [DW-1:0] pull_up;
        logic [DW-1:0] pull_dn;
    } ppa_ph_pad_t;

    typedef struct packed {
        logic [DW-1:0] dout;
        logic [DW-1:0] oe;
    } ppa_ad_pad_t;

    typedef struct packed {
        logic [DW-1:0] analog_port_data;
        logic [DW-1:0] analog_port_direction;
        logic [DW-1:0] port_h_direction;
        logic [DW-1:0] port_h_drive_strength;
        logic [DW-1:0] port_h_pull_enable;
        logic [DW-1:0] port_h_pull_polarity;
        logic [DW-1:0] port_h_open_drain_mode;
    } ppa_regs_t;

    localparam ppa_regs_t REGS_RESET = '{
        analog_port_data: RST_ZERO,
        analog_port_direction: RST_ZERO,
        port_h_direction: RST_ZERO,
        port_h_drive_strength: RST_ZERO,
        port_h_pull_enable: RST_PULL_EN,
        port_h_pull_polarity: RST_ZERO,
        port_h_open_drain_mode: RST_ZERO
    };

endpackage

// ===== core/ppa_sync.sv
// Two-stage synchroniser for the eight analog port input levels.
// Assumes the pin levels may change at any time relative to CORE_CLK.

`timescale 1ns/1ps

module ppa_sync (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [ppa_pkg::DW-1:0] PIN_IN,
    output logic [ppa_pkg::DW-1:0] PIN_SYNC
);

    typedef struct packed {
        logic [ppa_pkg::DW-1:0] stage1;
        logic [ppa_pkg::DW-1:0] stage2;
    } ppa_sync_st_t;

    ppa_sync_st_t st_ff;
    ppa_sync_st_t nxt_st;

    // Stage one feeds only stage two
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1 = PIN_IN;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= '{stage1: ppa_pkg::RST_ZERO, stage2: ppa_pkg::RST_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign PIN_SYNC = st_ff.stage2;

endmodule

// ===== core/ppa_top.sv
// Port H pad configuration and analog port data logic behind a
// classic Wishbone slave.
// Assumes one clock, pins synchronous to it except the analog port
// inputs, and a separate block that owns the port H data register.
//
// What this block does
// - A set drive bit on a port H output pin selects one sixth drive, and is ignored on inputs.
// - A set pull enable bit on a port H pin turns its pull device on only while it is an input.
// - The port H pull enable register resets with all eight bits set.
// - A polarity bit of one picks a pull-down and zero a pull-up, only for enabled input pins.
// - A set wired-or bit makes the port H output drive low only and never drive high.
// - The wired-or bit leaves a port H pin that is an input untouched.
// - An analog port pin not claimed by the converter works as ordinary port I/O.
// - In output mode each bit of the analog port data register is driven to its pin unless the converter claims that pin.
// - Reading analog port data gives the stored bit where direction is one, else the pin.
// - Reserved locations read as zero and ignore writes.
// - A direction bit of one makes the pin an output and zero an input.
// - After a direction change the read source may take up to two cycles to settle.

`timescale 1ns/1ps

module ppa_top (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input ppa_pkg::ppa_wb_req_t WB_REQ,
    output ppa_pkg::ppa_wb_rsp_t WB_RSP,
    input wire logic [ppa_pkg::DW-1:0] PH_OUT_VAL,
    input wire logic [ppa_pkg::DW-1:0] AD_PIN_IN,
    input wire logic [ppa_pkg::DW-1:0] AD_ANALOG_CLAIM,
    output ppa_pkg::ppa_ph_pad_t PH_PAD,
    output ppa_pkg::ppa_ad_pad_t AD_PAD
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ppa_pkg::ppa_regs_t regs;
        ppa_pkg::ppa_wb_rsp_t rsp;
        ppa_pkg::ppa_ph_pad_t ph_pad;
        ppa_pkg::ppa_ad_pad_t ad_pad;
    } ppa_top_st_t;

    ppa_top_st_t st_ff;
    ppa_top_st_t nxt_st;
    logic [ppa_pkg::DW-1:0] ad_pin_sync;

    // ****************************************************************
    // Input synchroniser
    // ****************************************************************
    ppa_sync u_ad_sync (
        .CORE_CLK(CORE_CLK),
        .RESETN(RESETN),
        .PIN_IN(AD_PIN_IN),
        .PIN_SYNC(ad_pin_sync)
    );

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [ppa_pkg::IDX_W-1:0] reg_index(
        input logic [ppa_pkg::WB_AW-1:0] adr
    );
        return adr[ppa_pkg::ADR_IDX_MSB:ppa_pkg::ADR_IDX_LSB];
    endfunction

    // Per-bit source select used by the analog port data read
    function automatic logic [ppa_pkg::DW-1:0] data_read(
        input logic [ppa_pkg::DW-1:0] stored,
        input logic [ppa_pkg::DW-1:0] dir,
        input logic [ppa_pkg::DW-1:0] pin
    );
        return (stored & dir) | (pin & ~dir);
    endfunction

    function automatic logic is_reserved(
        input logic [ppa_pkg::IDX_W-1:0] idx
    );
        logic hit;
        hit = 1'b0;
        if (idx == ppa_pkg::IDX_RSVD_A) begin
            hit = 1'b1;
        end else if (idx == ppa_pkg::IDX_RSVD_B) begin
            hit = 1'b1;
        end else if (idx == ppa_pkg::IDX_RSVD_C) begin
            hit = 1'b1;
        end else if (idx == ppa_pkg::IDX_RSVD_AD) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Read decode; reserved and unmapped indices fall through to zero
    function automatic logic [ppa_pkg::DW-1:0] read_byte(
        input ppa_pkg::ppa_regs_t regs,
        input logic [ppa_pkg::IDX_W-1:0] idx,
        input logic [ppa_pkg::DW-1:0] pin
    );
        logic [ppa_pkg::DW-1:0] val;
        val = ppa_pkg::RSVD_READ;
        if (is_reserved(idx)) begin
            val = ppa_pkg::RSVD_READ;
        end else if (idx == ppa_pkg::IDX_AD_DATA) begin
            // Source switches at once with direction; the pin path lags by
            // the synchroniser depth, so software should wait two cycles
            val = data_read(regs.analog_port_data, regs.analog_port_direction,
                pin);
        end else if (idx == ppa_pkg::IDX_AD_DIR) begin
            val = regs.analog_port_direction;
        end else if (idx == ppa_pkg::IDX_PH_DIR) begin
            val = regs.port_h_direction;
        end else if (idx == ppa_pkg::IDX_PH_DRIVE) begin
            val = regs.port_h_drive_strength;
        end else if (idx == ppa_pkg::IDX_PH_PULL_EN) begin
            val = regs.port_h_pull_enable;
        end else if (idx == ppa_pkg::IDX_PH_PULL_POL) begin
            val = regs.port_h_pull_polarity;
        end else if (idx == ppa_pkg::IDX_PH_OPEN_DRAIN) begin
            val = regs.port_h_open_drain_mode;
        end
        return val;
    endfunction

    // Write decode; reserved and unmapped indices leave all state alone
    function automatic ppa_pkg::ppa_regs_t write_byte(
        input ppa_pkg::ppa_regs_t regs,
        input logic [ppa_pkg::IDX_W-1:0] idx,
        input logic [ppa_pkg::DW-1:0] val
    );
        ppa_pkg::ppa_regs_t r;
        r = regs;
        if (is_reserved(idx)) begin
            r = regs;
        end else if (idx == ppa_pkg::IDX_AD_DATA) begin
            r.analog_port_data = val;
        end else if (idx == ppa_pkg::IDX_AD_DIR) begin
            r.analog_port_direction = val;
        end else if (idx == ppa_pkg::IDX_PH_DIR) begin
            r.port_h_direction = val;
        end else if (idx == ppa_pkg::IDX_PH_DRIVE) begin
            r.port_h_drive_strength = val;
        end else if (idx == ppa_pkg::IDX_PH_PULL_EN) begin
            r.port_h_pull_enable = val;
        end else if (idx == ppa_pkg::IDX_PH_PULL_POL) begin
            r.port_h_pull_polarity = val;
        end else if (idx == ppa_pkg::IDX_PH_OPEN_DRAIN) begin
            r.port_h_open_drain_mode = val;
        end
        return r;
    endfunction

    // Port H pad controls from the configuration and the output value
    function automatic ppa_pkg::ppa_ph_pad_t ph_pad_ctl(
        input ppa_pkg::ppa_regs_t regs,
        input logic [ppa_pkg::DW-1:0] out_val
    );
        ppa_pkg::ppa_ph_pad_t p;
        logic [ppa_pkg::DW-1:0] is_out;
        logic [ppa_pkg::DW-1:0] pull_on;
        is_out = regs.port_h_direction;
        p.dout = out_val;
        // Open-drain releases the pin instead of driving a high level
        p.oe = is_out & ~(regs.port_h_open_drain_mode & out_val);
        // Input pins never see the wired-or bit, only the direction
        p.oe = p.oe & is_out;
        p.reduced = regs.port_h_drive_strength & is_out;
        pull_on = regs.port_h_pull_enable & ~is_out;
        p.pull_dn = pull_on & regs.port_h_pull_polarity;
        p.pull_up = pull_on & ~regs.port_h_pull_polarity;
        return p;
    endfunction

    // Analog port pad controls; a converter claim removes the driver
    function automatic ppa_pkg::ppa_ad_pad_t ad_pad_ctl(
        input ppa_pkg::ppa_regs_t regs,
        input logic [ppa_pkg::DW-1:0] claim
    );
        ppa_pkg::ppa_ad_pad_t p;
        p.dout = regs.analog_port_data;
        p.oe = regs.analog_port_direction & ~claim;
        return p;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    // The ack is given one cycle after the request is seen and the write
    // lands on the edge where the master samples it, so one access costs
    // two cycles; the trade buys a registered read path.
    always_comb begin
        logic req;
        logic [ppa_pkg::IDX_W-1:0] idx;
        logic [ppa_pkg::DW-1:0] wbyte;
        req = 1'b0;
        idx = '0;
        wbyte = ppa_pkg::RST_ZERO;
        nxt_st = st_ff;
        req = WB_REQ.cyc & WB_REQ.stb;
        idx = reg_index(WB_REQ.adr);
        wbyte = WB_REQ.dat[ppa_pkg::DW-1:0];
        if (req && !st_ff.rsp.ack) begin
            nxt_st.rsp.ack = 1'b1;
            nxt_st.rsp.dat = {ppa_pkg::UPPER_ZERO,
                read_byte(st_ff.regs, idx, ad_pin_sync)};
        end else begin
            nxt_st.rsp.ack = 1'b0;
            nxt_st.rsp.dat = {ppa_pkg::UPPER_ZERO, ppa_pkg::RSVD_READ};
        end
        // Only lane 0 carries register bits; other lanes are ignored
        if (req && st_ff.rsp.ack && WB_REQ.we && WB_REQ.sel[ppa_pkg::SEL_LANE0]) begin
            nxt_st.regs = write_byte(st_ff.regs, idx, wbyte);
        end
        // Pads follow the new register values, so a write acts next cycle
        nxt_st.ph_pad = ph_pad_ctl(nxt_st.regs, PH_OUT_VAL);
        nxt_st.ad_pad = ad_pad_ctl(nxt_st.regs, AD_ANALOG_CLAIM);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff.regs <= ppa_pkg::REGS_RESET;
            st_ff.rsp <= '{ack: 1'b0, dat: '0};
            // Pull-ups on all port H pins, everything else undriven
            st_ff.ph_pad <= '{
                dout: ppa_pkg::RST_ZERO,
                oe: ppa_pkg::RST_ZERO,
                reduced: ppa_pkg::RST_ZERO,
                pull_up: ppa_pkg::RST_PULL_EN,
                pull_dn: ppa_pkg::RST_ZERO
            };
            st_ff.ad_pad <= '{dout: ppa_pkg::RST_ZERO, oe: ppa_pkg::RST_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign WB_RSP = st_ff.rsp;
    assign PH_PAD = st_ff.ph_pad;
    assign AD_PAD = st_ff.ad_pad;

endmodule

// ===== test/ppa_pins.sv
// Model of the analog port pins as seen from outside the device.
// Assumes an outside source whose level the bench chooses per pin.
`timescale 1ns/1ps
module ppa_pins (
    input ppa_pkg::ppa_ad_pad_t ad_pad,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_in
);
    // A driven pin shows the pad value; an undriven one the outside source
    assign pin_in = (ad_pad.oe & ad_pad.dout) | (~ad_pad.oe & ext_level);
endmodule

// ===== test/ppa_top_chk.sv
// Port-level assertions for the port pad block.
// Assumes it is bound onto ppa_top and that the block has one clock.
`timescale 1ns/1ps
module ppa_top_chk (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input ppa_pkg::ppa_wb_req_t WB_REQ,
    input ppa_pkg::ppa_wb_rsp_t WB_RSP,
    input wire logic [ppa_pkg::DW-1:0] PH_OUT_VAL,
    input wire logic [ppa_pkg::DW-1:0] AD_ANALOG_CLAIM,
    input ppa_pkg::ppa_ph_pad_t PH_PAD,
    input ppa_pkg::ppa_ad_pad_t AD_PAD
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    a_ack_answer: assert property (
        WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack) else $error("ack late");
    a_ack_pulse: assert property (
        WB_RSP.ack |=> !WB_RSP.ack) else $error("ack longer than one cycle");
    a_idle_data: assert property (
        !WB_RSP.ack |-> WB_RSP.dat == 32'h00000000) else $error("data outside ack");
    a_upper_lanes: assert property (
        WB_RSP.ack |-> WB_RSP.dat[31:8] == 24'h000000) else $error("upper lanes not zero");
    a_rsvd_zero: assert property (
        WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !WB_RSP.ack
        && WB_REQ.adr[15:2] == ppa_pkg::IDX_RSVD_AD |=> WB_RSP.dat == 32'h00000000)
        else $error("reserved read not zero");
    a_pull_excl: assert property (
        (PH_PAD.pull_up & PH_PAD.pull_dn) == 8'h00) else $error("both pulls on");
    a_drive_pull: assert property (
        (PH_PAD.reduced & (PH_PAD.pull_up | PH_PAD.pull_dn)) == 8'h00)
        else $error("pull on an output pin");
    a_claim_oe: assert property (
        (AD_PAD.oe & $past(AD_ANALOG_CLAIM)) == 8'h00) else $error("claimed pin driven");
    a_dout_follow: assert property (
        PH_PAD.dout == $past(PH_OUT_VAL)) else $error("port H value not passed on");
endmodule
bind ppa_top ppa_top_chk u_chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .WB_REQ(WB_REQ),
    .WB_RSP(WB_RSP), .PH_OUT_VAL(PH_OUT_VAL), .AD_ANALOG_CLAIM(AD_ANALOG_CLAIM),
    .PH_PAD(PH_PAD), .AD_PAD(AD_PAD));

// ===== test/ppa_top_tb.sv
// Self-checking bench for the port pad block.
// Assumes ppa_top, the pin model and the bound checker are compiled first.
`timescale 1ns/1ps
module ppa_top_tb;
    logic clk;
    logic rst_n;
    ppa_pkg::ppa_wb_req_t req;
    ppa_pkg::ppa_wb_rsp_t rsp;
    logic [7:0] ph_val, claim, ext, pin;
    ppa_pkg::ppa_ph_pad_t ph;
    ppa_pkg::ppa_ad_pad_t ad;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] rd;

    ppa_top dut (.CORE_CLK(clk), .RESETN(rst_n), .WB_REQ(req), .WB_RSP(rsp),
        .PH_OUT_VAL(ph_val), .AD_PIN_IN(pin), .AD_ANALOG_CLAIM(claim),
        .PH_PAD(ph), .AD_PAD(ad));
    ppa_pins u_pins (.ad_pad(ad), .ext_level(ext), .pin_in(pin));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [13:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'h1, 1'h1, we, {idx, 2'h0}, 4'hF, {24'h000000, wd}};
        // Ack is sampled as it stood before the edge, as a real master sees it
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'h1 && n < 50);
        // A slave that never answers ends the run through the one verdict
        if (n >= 50) begin
            n_errors++;
            complete_run();
        end
        rd = rsp.dat[7:0];
        req <= '0;
    endtask

    task automatic rchk(input logic [13:0] idx, input logic [7:0] exp);
        wb(1'h0, idx, 8'h00);
        chk(rd, exp);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        logic [13:0] idx [7];
        logic [7:0] rst [7];
        idx = '{ppa_pkg::IDX_PH_DIR, ppa_pkg::IDX_PH_DRIVE, ppa_pkg::IDX_PH_PULL_EN,
            ppa_pkg::IDX_PH_PULL_POL, ppa_pkg::IDX_PH_OPEN_DRAIN, ppa_pkg::IDX_AD_DIR,
            ppa_pkg::IDX_AD_DATA};
        rst = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
        foreach (idx[i]) rchk(idx[i], rst[i]);
        // Data register is left out: with direction 0 it reads the pins
        for (int i = 0; i < 6; i++) begin
            wb(1'h1, idx[i], 8'h5A);
            rchk(idx[i], 8'h5A);
            wb(1'h1, idx[i], 8'hA5);
            rchk(idx[i], 8'hA5);
        end
    endtask

    task automatic t_rsvd;
        logic [13:0] idx [5];
        idx = '{ppa_pkg::IDX_RSVD_A, ppa_pkg::IDX_RSVD_B, ppa_pkg::IDX_RSVD_C,
            ppa_pkg::IDX_RSVD_AD, 14'h0300};
        foreach (idx[i]) begin
            wb(1'h1, idx[i], 8'hFF);
            rchk(idx[i], 8'h00);
        end
    endtask

    task automatic t_port_h;
        wb(1'h1, ppa_pkg::IDX_PH_DIR, 8'hF0);
        wb(1'h1, ppa_pkg::IDX_PH_DRIVE, 8'hFF);
        wb(1'h1, ppa_pkg::IDX_PH_PULL_EN, 8'hFF);
        wb(1'h1, ppa_pkg::IDX_PH_PULL_POL, 8'hCC);
        wb(1'h1, ppa_pkg::IDX_PH_OPEN_DRAIN, 8'h00);
        ph_val <= 8'hAA;
        repeat (3) @(posedge clk);
        chk(ph.reduced, 8'hF0);
        chk(ph.pull_up, 8'h03);
        chk(ph.pull_dn, 8'h0C);
        chk(ph.oe, 8'hF0);
        wb(1'h1, ppa_pkg::IDX_PH_OPEN_DRAIN, 8'hFF);
        repeat (3) @(posedge clk);
        chk(ph.oe, 8'h50);
        chk(ph.dout, 8'hAA);
        chk(ph.pull_up | ph.pull_dn, 8'h0F);
    endtask

    task automatic t_analog;
        ext <= 8'h3C;
        claim <= 8'hC0;
        wb(1'h1, ppa_pkg::IDX_AD_DATA, 8'hA5);
        wb(1'h1, ppa_pkg::IDX_AD_DIR, 8'hF0);
        repeat (4) @(posedge clk);
        chk(ad.dout, 8'hA5);
        chk(ad.oe, 8'h30);
        rchk(ppa_pkg::IDX_AD_DATA, 8'hAC);
        wb(1'h1, ppa_pkg::IDX_AD_DIR, 8'h00);
        // Pin level needs the synchroniser depth before a read shows it
        repeat (4) @(posedge clk);
        rchk(ppa_pkg::IDX_AD_DATA, 8'h3C);
        ext <= 8'hC3;
        repeat (4) @(posedge clk);
        rchk(ppa_pkg::IDX_AD_DATA, 8'hC3);
    endtask

    // ****************************************************************
    // Run control
    // ****************************************************************
    task automatic complete_run;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        rst_n = 1'h0;
        req = '0;
        ph_val = 8'h00;
        claim = 8'h00;
        ext = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_rsvd();
        t_port_h();
        t_analog();
        complete_run();
    end
endmodule
